// ---- rtl/aofc_pkg.sv ----
// package: register map, field positions, reset values and pattern codes of the output format bank
package aofc_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_STATS_SOURCE_SELECT = 8'h02;
	localparam logic [7:0] OFS_LANE_BIT_ORDER_CTRL = 8'h03;
	localparam logic [7:0] OFS_LANE_SWAP_CTRL = 8'h04;
	localparam logic [7:0] OFS_LANE_COUNT_CTRL = 8'h05;
	localparam logic [7:0] OFS_PATTERN_ENABLE_SOFT_RESET = 8'h06;
	localparam logic [7:0] OFS_OVERRANGE_LSB_CTRL = 8'h07;
	localparam logic [7:0] OFS_OUTPUT_FORMAT_CTRL = 8'h09;
	localparam logic [7:0] OFS_PATTERN_CODE_AB = 8'h0a;
	localparam logic [7:0] OFS_PATTERN_CODE_CD = 8'h0b;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int POS_STATS_CHANNEL_SELECT = 6;
	localparam int POS_BIT_ORDER = 0;
	localparam int POS_LANE_SWAP = 0;
	localparam int POS_LANE_COUNT_SELECT = 0;
	localparam int POS_SOFT_RESET = 0;
	localparam int POS_PATTERN_ENABLE = 1;
	localparam int POS_OVERRANGE_IN_LSB = 0;
	localparam int POS_NUMBER_FORMAT = 0;
	localparam int POS_PATTERN_ALIGN = 1;
	localparam int POS_CODE_HI = 4;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [3:0] RST_PATTERN_CODE = 4'h0;
	// ----------------------------------------
	// sample and pattern constants
	// ----------------------------------------
	localparam int SAMPLE_W = 12;
	localparam int LANE_HALF = 6;
	localparam logic [3:0] PAT_NORMAL = 4'h0;
	localparam logic [3:0] PAT_ZEROS = 4'h1;
	localparam logic [3:0] PAT_ONES = 4'h2;
	localparam logic [3:0] PAT_TOGGLE = 4'h3;
	localparam logic [3:0] PAT_RAMP = 4'h4;
	localparam logic [3:0] PAT_DESKEW = 4'h6;
	localparam logic [11:0] TOGGLE_A = 12'haaa;
	localparam logic [11:0] DESKEW_WORD = 12'haaa;
endpackage : aofc_pkg

// ---- rtl/aofc_top.sv ----
// output format control bank: registers and per-channel sample formatting onto two serial lanes
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module aofc_top import aofc_pkg::*; #(
	parameter int NUM_CH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// converter samples, one strobe per sample period, two's complement
	input wire logic sample_valid,
	input wire logic [NUM_CH*SAMPLE_W-1:0] sample_data,
	input wire logic [NUM_CH-1:0] overrange_flag,
	// formatted words: lane0 and lane1 bit groups per channel
	output logic word_valid,
	output logic [NUM_CH*SAMPLE_W-1:0] word_data,
	output logic [NUM_CH*LANE_HALF-1:0] lane0_pair,
	output logic [NUM_CH*LANE_HALF-1:0] lane1_pair,
	output logic [NUM_CH-1:0] lane1_active,
	// statistics source
	output logic [1:0] stats_channel_select,
	output logic [SAMPLE_W-1:0] stats_sample
);
	initial begin
		if (NUM_CH != 4) $error("aofc_top: NUM_CH must be 4");
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [1:0] stats_sel_q;
	logic bit_order_q;
	logic lane_swap_q;
	logic lane_count_select_q;
	logic pattern_enable_q;
	logic soft_reset_q;
	logic overrange_in_lsb_q;
	logic pattern_align_q;
	logic number_format_q;
	logic [3:0] pattern_code_q [NUM_CH];
	logic rst_all;

	// soft reset acts one cycle after the write and restores every field
	assign rst_all = srst | soft_reset_q;

	// self-clearing soft reset bit; set by a write of 1, gone the next cycle
	always_ff @(posedge clk) begin
		if (srst || soft_reset_q) begin
			soft_reset_q <= 1'b0;
		end else if (reg_wr && reg_addr == OFS_PATTERN_ENABLE_SOFT_RESET) begin
			soft_reset_q <= reg_wdata[POS_SOFT_RESET];
		end
	end

	// configuration fields; unassigned bits are dropped, host writes them as zero
	always_ff @(posedge clk) begin
		if (rst_all) begin
			stats_sel_q <= RST_REG[1:0];
			bit_order_q <= 1'b0;
			lane_swap_q <= 1'b0;
			lane_count_select_q <= 1'b0;
			pattern_enable_q <= 1'b0;
			overrange_in_lsb_q <= 1'b0;
			pattern_align_q <= 1'b0;
			number_format_q <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				pattern_code_q[i] <= RST_PATTERN_CODE;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_STATS_SOURCE_SELECT: begin
					stats_sel_q <= reg_wdata[POS_STATS_CHANNEL_SELECT +: 2];
				end
				OFS_LANE_BIT_ORDER_CTRL: begin
					bit_order_q <= reg_wdata[POS_BIT_ORDER];
				end
				OFS_LANE_SWAP_CTRL: begin
					lane_swap_q <= reg_wdata[POS_LANE_SWAP];
				end
				OFS_LANE_COUNT_CTRL: begin
					lane_count_select_q <= reg_wdata[POS_LANE_COUNT_SELECT];
				end
				OFS_PATTERN_ENABLE_SOFT_RESET: begin
					pattern_enable_q <= reg_wdata[POS_PATTERN_ENABLE];
				end
				OFS_OVERRANGE_LSB_CTRL: begin
					overrange_in_lsb_q <= reg_wdata[POS_OVERRANGE_IN_LSB];
				end
				OFS_OUTPUT_FORMAT_CTRL: begin
					number_format_q <= reg_wdata[POS_NUMBER_FORMAT];
					pattern_align_q <= reg_wdata[POS_PATTERN_ALIGN];
				end
				OFS_PATTERN_CODE_AB: begin
					pattern_code_q[0] <= reg_wdata[POS_CODE_HI +: 4];
					pattern_code_q[1] <= reg_wdata[3:0];
				end
				OFS_PATTERN_CODE_CD: begin
					pattern_code_q[2] <= reg_wdata[POS_CODE_HI +: 4];
					pattern_code_q[3] <= reg_wdata[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// read data one cycle after the strobe; write-only bits read as zero
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= RST_REG;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_STATS_SOURCE_SELECT: reg_rdata <= {stats_sel_q, 6'h00};
				OFS_LANE_BIT_ORDER_CTRL: reg_rdata <= {7'h00, bit_order_q};
				OFS_LANE_SWAP_CTRL: reg_rdata <= {7'h00, lane_swap_q};
				OFS_LANE_COUNT_CTRL: reg_rdata <= {7'h00, lane_count_select_q};
				OFS_PATTERN_ENABLE_SOFT_RESET: reg_rdata <= {6'h00, pattern_enable_q, soft_reset_q};
				OFS_OVERRANGE_LSB_CTRL: reg_rdata <= {7'h00, overrange_in_lsb_q};
				OFS_OUTPUT_FORMAT_CTRL: reg_rdata <= {6'h00, pattern_align_q, number_format_q};
				OFS_PATTERN_CODE_AB: reg_rdata <= {pattern_code_q[0], pattern_code_q[1]};
				OFS_PATTERN_CODE_CD: reg_rdata <= {pattern_code_q[2], pattern_code_q[3]};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// pattern generator timing
	// ----------------------------------------
	logic [SAMPLE_W-1:0] ramp_q [NUM_CH];
	logic [NUM_CH-1:0] toggle_q;
	logic pat_on_q;

	// ramps and toggles per channel step once per sample strobe; align forces all to channel 0
	always_ff @(posedge clk) begin
		if (rst_all) begin
			pat_on_q <= 1'b0;
			toggle_q <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				ramp_q[i] <= '0;
			end
		end else begin
			// enable edge is tracked every cycle so an off-on pair between samples still restarts
			pat_on_q <= pattern_enable_q;
			for (int i = 0; i < NUM_CH; i++) begin
				// a channel restarts whenever patterns are newly enabled
				if (pattern_enable_q && !pat_on_q) begin
					ramp_q[i] <= '0;
					toggle_q[i] <= 1'b0;
				end else if (!sample_valid) begin
					// hold between samples
				end else if (pattern_align_q && i != 0) begin
					ramp_q[i] <= ramp_q[0] + 12'h001;
					toggle_q[i] <= ~toggle_q[0];
				end else begin
					ramp_q[i] <= ramp_q[i] + 12'h001;
					toggle_q[i] <= ~toggle_q[i];
				end
			end
		end
	end

	// ----------------------------------------
	// formatting functions
	// ----------------------------------------
	// pattern word for one code; unlisted codes give zeros
	function automatic logic [SAMPLE_W-1:0] pattern_word(input logic [3:0] code, input logic [SAMPLE_W-1:0] ramp,
		input logic tog);
		case (code)
			PAT_ZEROS: pattern_word = '0;
			PAT_ONES: pattern_word = '1;
			PAT_TOGGLE: pattern_word = tog ? ~TOGGLE_A : TOGGLE_A;
			PAT_RAMP: pattern_word = ramp;
			PAT_DESKEW: pattern_word = DESKEW_WORD;
			default: pattern_word = '0;
		endcase
	endfunction : pattern_word

	// split a word into lane 0 and lane 1 groups
	function automatic logic [2*LANE_HALF-1:0] lane_split(input logic [SAMPLE_W-1:0] w, input logic odd_even);
		logic [LANE_HALF-1:0] l0;
		logic [LANE_HALF-1:0] l1;
		l0 = w[LANE_HALF-1:0];
		l1 = w[SAMPLE_W-1:LANE_HALF];
		if (odd_even) begin
			for (int b = 0; b < LANE_HALF; b++) begin
				l0[b] = w[2*b];
				l1[b] = w[2*b+1];
			end
		end
		lane_split = {l1, l0};
	endfunction : lane_split

	// ----------------------------------------
	// per-channel output path
	// ----------------------------------------
	logic [SAMPLE_W-1:0] fmt_word [NUM_CH];
	logic [2*LANE_HALF-1:0] split_word [NUM_CH];

	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			logic [SAMPLE_W-1:0] raw;
			logic [SAMPLE_W-1:0] coded;
			logic [SAMPLE_W-1:0] src;
			assign raw = sample_data[c*SAMPLE_W +: SAMPLE_W];
			// offset binary inverts the sign bit of two's complement
			assign coded = number_format_q ? {~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]} : raw;
			// pattern replaces data only when enabled and code is not normal
			assign src = (pattern_enable_q && pattern_code_q[c] != PAT_NORMAL)
				? pattern_word(pattern_code_q[c], ramp_q[c], toggle_q[c]) : coded;
			// overrange replaces the least significant bit
			assign fmt_word[c] = overrange_in_lsb_q ? {src[SAMPLE_W-1:1], overrange_flag[c]} : src;
			// one-lane mode ignores bit order
			assign split_word[c] = lane_split(fmt_word[c], bit_order_q && !lane_count_select_q);
		end
	endgenerate

	// registered outputs; word and lane groups update once per sample strobe, word_valid and lane1_active every cycle
	always_ff @(posedge clk) begin
		if (rst_all) begin
			word_valid <= 1'b0;
			word_data <= '0;
			lane0_pair <= '0;
			lane1_pair <= '0;
			lane1_active <= '1;
		end else begin
			word_valid <= sample_valid;
			if (sample_valid) begin
				for (int c = 0; c < NUM_CH; c++) begin
					word_data[c*SAMPLE_W +: SAMPLE_W] <= fmt_word[c];
					if (lane_count_select_q) begin
						// one lane: low six bits of the word go out on lane 0, lane 1 idle
						lane0_pair[c*LANE_HALF +: LANE_HALF] <= split_word[c][LANE_HALF-1:0];
						lane1_pair[c*LANE_HALF +: LANE_HALF] <= '0;
					end else if (lane_swap_q) begin
						lane0_pair[c*LANE_HALF +: LANE_HALF] <= split_word[c][2*LANE_HALF-1:LANE_HALF];
						lane1_pair[c*LANE_HALF +: LANE_HALF] <= split_word[c][LANE_HALF-1:0];
					end else begin
						lane0_pair[c*LANE_HALF +: LANE_HALF] <= split_word[c][LANE_HALF-1:0];
						lane1_pair[c*LANE_HALF +: LANE_HALF] <= split_word[c][2*LANE_HALF-1:LANE_HALF];
					end
				end
			end
			lane1_active <= {NUM_CH{~lane_count_select_q}};
		end
	end

	// statistics source selection
	always_ff @(posedge clk) begin
		if (rst_all) begin
			stats_channel_select <= 2'h0;
			stats_sample <= '0;
		end else begin
			stats_channel_select <= stats_sel_q;
			if (sample_valid) begin
				stats_sample <= fmt_word[stats_sel_q];
			end
		end
	end
endmodule : aofc_top
`default_nettype wire

// ---- verification/aofc_props.sv ----
// checker: port-level properties of the output format bank
`timescale 1ns/100ps
`default_nettype none
module aofc_props import aofc_pkg::*; #(
	parameter int NUM_CH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// samples and formatted words
	input wire logic sample_valid,
	input wire logic [NUM_CH-1:0] overrange_flag,
	input wire logic word_valid,
	input wire logic [NUM_CH*SAMPLE_W-1:0] word_data,
	input wire logic [NUM_CH*LANE_HALF-1:0] lane0_pair,
	input wire logic [NUM_CH*LANE_HALF-1:0] lane1_pair,
	input wire logic [NUM_CH-1:0] lane1_active,
	input wire logic [1:0] stats_channel_select,
	input wire logic [SAMPLE_W-1:0] stats_sample
);
	logic ord_q, swp_q, ovr_q, pat_q;
	logic [11:0] w;
	assign w = word_data[11:0];
	// shadow of the controls, cleared by either reset
	always_ff @(posedge clk) begin
		if (srst || (reg_wr && reg_addr == OFS_PATTERN_ENABLE_SOFT_RESET && reg_wdata[0])) begin
			{ord_q, swp_q, ovr_q, pat_q} <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == OFS_LANE_BIT_ORDER_CTRL) ord_q <= reg_wdata[0];
			if (reg_addr == OFS_LANE_SWAP_CTRL) swp_q <= reg_wdata[0];
			if (reg_addr == OFS_OVERRANGE_LSB_CTRL) ovr_q <= reg_wdata[0];
			if (reg_addr == OFS_PATTERN_ENABLE_SOFT_RESET) pat_q <= reg_wdata[1];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_soft;
		reg_wr && reg_addr == OFS_PATTERN_ENABLE_SOFT_RESET && reg_wdata[0];
	endsequence
	sequence s_two;
		word_valid && lane1_active[0];
	endsequence
	AST_WORD_VALID: assert property (sample_valid |=> word_valid) else $error("word strobe missing");
	AST_WORD_PULSE: assert property (!sample_valid |=> !word_valid) else $error("word strobe without sample");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside slot");
	AST_RD_UNMAPPED: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata == 8'h00) else $error("unmapped read");
	AST_WO_BITS: assert property (reg_rd && reg_addr == OFS_LANE_COUNT_CTRL |=> reg_rdata[7:1] == 7'h00)
		else $error("write-only bits read back");
	AST_ONE_LANE: assert property (word_valid && !lane1_active[0] |-> lane1_pair[5:0] == 6'h00 && lane0_pair[5:0] == w[5:0])
		else $error("one-lane layout wrong");
	AST_ORDER0: assert property ((s_two and (!ord_q && !swp_q)) |-> lane0_pair[5:0] == w[5:0] && lane1_pair[5:0] == w[11:6])
		else $error("sequential layout wrong");
	AST_ORDER1: assert property ((s_two and (ord_q && !swp_q)) |-> lane0_pair[5:0] == {w[10], w[8], w[6], w[4], w[2], w[0]})
		else $error("interleaved layout wrong");
	AST_SWAP: assert property ((s_two and (!ord_q && swp_q)) |-> lane1_pair[5:0] == w[5:0] && lane0_pair[5:0] == w[11:6])
		else $error("lane swap wrong");
	AST_OVR: assert property (word_valid && ovr_q && !pat_q |-> word_data[0] == $past(overrange_flag[0]))
		else $error("overrange bit wrong");
	AST_STATS: assert property (word_valid && $stable(stats_channel_select) |->
		stats_sample == word_data[stats_channel_select*12 +: 12]) else $error("stats source wrong");
	AST_SOFT_RESET: assert property (s_soft |-> ##[1:3] (stats_channel_select == 2'h0 && lane1_active == 4'hf))
		else $error("soft reset incomplete");
endmodule : aofc_props
bind aofc_top aofc_props #(.NUM_CH(NUM_CH)) i_aofc_props (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
	.overrange_flag(overrange_flag), .word_valid(word_valid), .word_data(word_data), .lane0_pair(lane0_pair),
	.lane1_pair(lane1_pair), .lane1_active(lane1_active), .stats_channel_select(stats_channel_select),
	.stats_sample(stats_sample));
`default_nettype wire

// ---- verification/aofc_sink.sv ----
// partner: host logic capturing the lane groups of each word
`timescale 1ns/100ps
`default_nettype none
module aofc_sink (
	// clock
	input wire logic clk,
	// lane groups from the bank
	input wire logic word_valid,
	input wire logic [23:0] lane0_pair,
	input wire logic [23:0] lane1_pair,
	// captured groups
	output logic [23:0] cap0,
	output logic [23:0] cap1
);
	// take both lanes on each word strobe, idle lane included
	always @(posedge clk) begin
		if (word_valid) begin
			cap0 <= lane0_pair;
			cap1 <= lane1_pair;
		end
	end
endmodule : aofc_sink
`default_nettype wire

// ---- verification/aofc_top_tb.sv ----
// testbench: registers, lane layout, formats, patterns and soft reset of the output format bank
`timescale 1ns/100ps
`default_nettype none
module aofc_top_tb import aofc_pkg::*;;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, sample_valid = 1'b0, word_valid;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [47:0] sample_data = 48'h0, word_data, smp;
	logic [3:0] overrange_flag = 4'h0, lane1_active;
	logic [23:0] lane0_pair, lane1_pair, cap0, cap1;
	logic [1:0] stats_channel_select;
	logic [11:0] stats_sample, l;
	int n_fail = 0, comparisons = 0, cyc = 0;
	aofc_top #(.NUM_CH(4)) i_aofc_top (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.sample_data(sample_data), .overrange_flag(overrange_flag), .word_valid(word_valid), .word_data(word_data),
		.lane0_pair(lane0_pair), .lane1_pair(lane1_pair), .lane1_active(lane1_active),
		.stats_channel_select(stats_channel_select), .stats_sample(stats_sample));
	aofc_sink i_aofc_sink (.clk(clk), .word_valid(word_valid), .lane0_pair(lane0_pair), .lane1_pair(lane1_pair),
		.cap0(cap0), .cap1(cap1));
	// clock and hang guard
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read strobe, data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(48'(reg_rdata), 48'(e));
	endtask : rd
	// one sample strobe, then one cycle for the host capture
	task automatic snd(input logic [47:0] d, input logic [3:0] o);
		@(posedge clk);
		sample_valid <= 1'b1;
		sample_data <= d;
		overrange_flag <= o;
		@(posedge clk);
		sample_valid <= 1'b0;
		@(posedge clk);
		#1;
	endtask : snd
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int i = 2; i < 10; i++) rd(8'(i), 8'h00);
		$display("test reset values done");
		smp = 48'h444_333_222_111;
		for (int s = 0; s < 4; s++) begin
			wr(OFS_STATS_SOURCE_SELECT, 8'(s << 6));
			rd(OFS_STATS_SOURCE_SELECT, 8'(s << 6));
			snd(smp, 4'h0);
			chk(48'(stats_sample), 48'(smp[s*12 +: 12]));
			chk(48'(stats_channel_select), 48'(s));
		end
		$display("test stats source done");
		for (int k = 0; k < 8; k++) begin
			wr(OFS_LANE_BIT_ORDER_CTRL, {7'h0, k[0]});
			wr(OFS_LANE_SWAP_CTRL, {7'h0, k[1]});
			wr(OFS_LANE_COUNT_CTRL, {7'h0, k[2]});
			snd(smp ^ 48'h9a5_3c1_e72_6b4, 4'h0);
			for (int c = 0; c < 4; c++) begin
				l = sample_data[c*12 +: 12];
				if (k[0]) l = {l[11], l[9], l[7], l[5], l[3], l[1], l[10], l[8], l[6], l[4], l[2], l[0]};
				if (k[2]) l = {6'h0, sample_data[c*12 +: 6]};
				else if (k[1]) l = {l[5:0], l[11:6]};
				chk(48'({cap1[c*6 +: 6], cap0[c*6 +: 6]}), 48'(l));
			end
			chk(48'(lane1_active), k[2] ? 48'h0 : 48'hf);
		end
		$display("test lane layout done");
		wr(OFS_OUTPUT_FORMAT_CTRL, 8'h01);
		snd(smp, 4'h0);
		chk(word_data, smp ^ 48'h800_800_800_800);
		wr(OFS_OUTPUT_FORMAT_CTRL, 8'h00);
		wr(OFS_OVERRANGE_LSB_CTRL, 8'h01);
		snd(smp, 4'ha);
		chk(word_data, 48'h445_332_223_110);
		wr(OFS_OVERRANGE_LSB_CTRL, 8'h00);
		snd(smp, 4'hf);
		chk(word_data, smp);
		$display("test number format done");
		wr(OFS_PATTERN_CODE_AB, 8'h12);
		wr(OFS_PATTERN_CODE_CD, 8'h36);
		snd(smp, 4'h0);
		chk(word_data, smp);
		wr(OFS_PATTERN_ENABLE_SOFT_RESET, 8'h02);
		snd(smp, 4'h0);
		chk(48'(word_data[23:0]), 48'hfff000);
		chk(48'(word_data[35:24] ^ {12{word_data[24]}}), 48'haaa);
		chk(48'(word_data[47:36]), 48'(DESKEW_WORD));
		wr(OFS_PATTERN_CODE_AB, 8'h44);
		wr(OFS_PATTERN_CODE_CD, 8'h44);
		wr(OFS_OUTPUT_FORMAT_CTRL, 8'h02);
		wr(OFS_PATTERN_ENABLE_SOFT_RESET, 8'h00);
		wr(OFS_PATTERN_ENABLE_SOFT_RESET, 8'h02);
		snd(smp, 4'h0);
		chk(word_data, 48'h0);
		snd(smp, 4'h0);
		chk(word_data, {4{12'h001}});
		$display("test patterns done");
		wr(OFS_PATTERN_ENABLE_SOFT_RESET, 8'h01);
		repeat (3) @(posedge clk);
		rd(OFS_STATS_SOURCE_SELECT, 8'h00);
		rd(OFS_PATTERN_ENABLE_SOFT_RESET, 8'h00);
		chk(48'(lane1_active), 48'hf);
		$display("test soft reset done");
		end_of_test();
	end
endmodule : aofc_top_tb
`default_nettype wire
